// *** verif/srmr_readout_tb.sv ***
// self-checking bench for the monitor readout register block
// assumes srmr_pkg is compiled first and this bench drives every input
`timescale 1ns/100ps
module srmr_readout_tb;
    import srmr_pkg::*;

    // ****************************************
    // signals and design instance
    // ****************************************
    // small top id so range faults are reachable
    localparam logic [ID_W-1:0] TOP_ID = 10'h00f;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic msr_wr = 1'b0;
    logic msr_rd = 1'b0;
    logic [1:0] msr_sel = 2'h0;
    logic [MSR_W-1:0] msr_wdata = 64'h0;
    logic [MSR_W-1:0] msr_rdata;
    logic msr_ack;
    logic msr_fault;
    logic upd_valid = 1'b0;
    srmr_upd_t upd_kind = UPD_OCC_INC;
    logic [ID_W-1:0] upd_id = 10'h000;
    logic data_unavail = 1'b0;
    logic [ID_W-1:0] active_id;
    int fails = 0;
    int checked = 0;

    srmr_readout #(.HIGHEST_ID(TOP_ID)) dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .msr_wr(msr_wr),
        .msr_rd(msr_rd),
        .msr_sel(msr_sel),
        .msr_wdata(msr_wdata),
        .msr_rdata(msr_rdata),
        .msr_ack(msr_ack),
        .msr_fault(msr_fault),
        .upd_valid(upd_valid),
        .upd_kind(upd_kind),
        .upd_id(upd_id),
        .data_unavail(data_unavail),
        .active_id(active_id)
    );

    always #20 sys_clk = ~sys_clk;

    // ****************************************
    // shared tasks
    // ****************************************
    function automatic logic [63:0] sel_word(input logic [9:0] id,
                                             input logic [7:0] ev);
        return {22'h0, id, 24'h0, ev};
    endfunction : sel_word

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : cmp

    // one access; the answer stands in the second cycle after the request
    task automatic reg_op(input logic wr, input logic [1:0] sel,
                          input logic [63:0] wd, input logic [63:0] exp_rd,
                          input logic exp_flt);
        @(posedge sys_clk);
        msr_wr <= wr;
        msr_rd <= ~wr;
        msr_sel <= sel;
        msr_wdata <= wd;
        @(posedge sys_clk);
        msr_wr <= 1'b0;
        msr_rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp({63'h0, msr_ack}, 64'h1, "ack");
        cmp({63'h0, msr_fault}, {63'h0, exp_flt}, "fault");
        if (!wr)
            cmp(msr_rdata, exp_rd, "read data");
    endtask : reg_op

    task automatic upd(input srmr_upd_t k, input logic [9:0] id,
                       input int n);
        @(posedge sys_clk);
        upd_valid <= 1'b1;
        upd_kind <= k;
        upd_id <= id;
        repeat (n) @(posedge sys_clk);
        upd_valid <= 1'b0;
    endtask : upd

    task automatic rd_ctr(input logic [9:0] id, input logic [7:0] ev,
                          input logic [63:0] exp);
        reg_op(1'b1, REG_SELECT, sel_word(id, ev), 64'h0, 1'b0);
        reg_op(1'b0, REG_COUNTER, 64'h0, exp, 1'b0);
    endtask : rd_ctr

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        cmp({54'h0, active_id}, 64'h0, "active id");
        reg_op(1'b0, REG_SELECT, 64'h0, 64'h0, 1'b0);
        reg_op(1'b0, REG_ASSOC, 64'h0, 64'h0, 1'b0);
        // event 0 unsupported, id 0 never counted
        reg_op(1'b0, REG_COUNTER, 64'h0, 64'hc000_0000_0000_0000,
               1'b0);
    endtask : t_reset

    task automatic t_events;
        upd(UPD_OCC_INC, 10'h003, 5);
        upd(UPD_OCC_DEC, 10'h003, 1);
        upd(UPD_BW_TOTAL, 10'h003, 3);
        upd(UPD_BW_LOCAL, 10'h003, 2);
        upd(UPD_OCC_INC, 10'h004, 2);
        rd_ctr(10'h003, EVT_OCC, 64'h4);
        rd_ctr(10'h003, EVT_BW_TOTAL, 64'h3);
        rd_ctr(10'h003, EVT_BW_LOCAL, 64'h2);
        rd_ctr(10'h004, EVT_OCC, 64'h2);
        rd_ctr(10'h004, EVT_BW_TOTAL, 64'h0);
        rd_ctr(10'h003, 8'h04, 64'h8000_0000_0000_0000);
        rd_ctr(10'h003, 8'h00, 64'h8000_0000_0000_0000);
    endtask : t_events

    task automatic t_unavail;
        rd_ctr(10'h005, EVT_OCC, 64'h4000_0000_0000_0000);
        @(posedge sys_clk);
        data_unavail <= 1'b1;
        rd_ctr(10'h003, EVT_OCC, 64'h4000_0000_0000_0000);
        @(posedge sys_clk);
        data_unavail <= 1'b0;
        rd_ctr(10'h003, EVT_OCC, 64'h4);
    endtask : t_unavail

    task automatic t_faults;
        logic [63:0] good;
        good = sel_word(TOP_ID, EVT_BW_LOCAL);
        reg_op(1'b1, REG_SELECT, good, 64'h0, 1'b0);
        reg_op(1'b1, REG_SELECT, good | 64'h100, 64'h0, 1'b1);
        reg_op(1'b1, REG_SELECT, good | 64'h1 << 63, 64'h0, 1'b1);
        reg_op(1'b1, REG_SELECT, sel_word(TOP_ID + 10'h1, 8'h01), 64'h0,
               1'b1);
        reg_op(1'b0, REG_SELECT, 64'h0, good, 1'b0);
        reg_op(1'b1, REG_ASSOC, 64'h5, 64'h0, 1'b0);
        reg_op(1'b1, REG_ASSOC, 64'h405, 64'h0, 1'b1);
        reg_op(1'b1, REG_ASSOC, 64'h10, 64'h0, 1'b1);
        reg_op(1'b0, REG_ASSOC, 64'h0, 64'h5, 1'b0);
        cmp({54'h0, active_id}, 64'h5, "active id");
        reg_op(1'b1, REG_COUNTER, 64'h0, 64'h0, 1'b1);
        reg_op(1'b0, 2'h3, 64'h0, 64'h0, 1'b1);
    endtask : t_faults

    // select write then counter read on the very next edge
    task automatic t_pipe;
        upd(UPD_OCC_DEC, 10'h006, 2);
        upd(UPD_OCC_INC, 10'h006, 1);
        @(posedge sys_clk);
        msr_wr <= 1'b1;
        msr_sel <= REG_SELECT;
        msr_wdata <= sel_word(10'h006, EVT_OCC);
        @(posedge sys_clk);
        msr_wr <= 1'b0;
        msr_rd <= 1'b1;
        msr_sel <= REG_COUNTER;
        @(posedge sys_clk);
        msr_rd <= 1'b0;
        #1;
        cmp({62'h0, msr_ack, msr_fault}, 64'h2, "write answer");
        @(posedge sys_clk);
        #1;
        cmp({63'h0, msr_ack}, 64'h1, "read answer");
        cmp(msr_rdata, 64'h1, "pipelined read");
    endtask : t_pipe

    // ****************************************
    // run control
    // ****************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_events();
        t_unavail();
        t_faults();
        t_pipe();
        finish_test();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        fails++;
        finish_test();
    end
endmodule : srmr_readout_tb

// *** verilog/srmr_id_store.sv ***
// per monitoring id count store, two registered read ports, one write
// assumes the caller forwards a write it reads back the next cycle
`timescale 1ns/100ps
module srmr_id_store
(
    input wire logic sys_clk,
    input wire logic reset,
    srmr_store_if.store st
);
    import srmr_pkg::*;

    logic [ENTRY_W-1:0] mem_q [0:DEPTH-1];
    logic [DEPTH-1:0] written_q;
    logic [DEPTH-1:0] written_d;
    logic [ENTRY_W-1:0] a_q;
    logic [ENTRY_W-1:0] b_q;
    logic a_vld_q;
    logic b_vld_q;

    // ****************************************
    // entry written flags
    // ****************************************
    // contents have no reset, so an unwritten entry reads as unavailable
    always_comb
    begin
        written_d = written_q;
        if (st.wr_en)
        begin
            written_d[st.wr_addr] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            written_q <= '0;
            a_vld_q <= 1'b0;
            b_vld_q <= 1'b0;
        end
        else
        begin
            written_q <= written_d;
            a_vld_q <= written_q[st.rd_a_addr];
            b_vld_q <= written_q[st.rd_b_addr];
        end
    end

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (st.wr_en)
        begin
            mem_q[st.wr_addr] <= st.wr_data;
        end
        a_q <= mem_q[st.rd_a_addr];
        b_q <= mem_q[st.rd_b_addr];
    end

    assign st.rd_a_data = a_q;
    assign st.rd_b_data = b_q;
    assign st.rd_a_valid = a_vld_q;
    assign st.rd_b_valid = b_vld_q;

endmodule : srmr_id_store

// *** verilog/srmr_pkg.sv ***
// constants, field layouts and types for the monitor readout block
// assumes a single 25 MHz clock domain and a synchronous reset
package srmr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ID_W = 10;
    localparam int EVT_W = 8;
    localparam int MSR_W = 64;
    localparam int OCC_W = 32;
    localparam int BW_W = 24;
    localparam int FIELD_W = 62;
    localparam int ENTRY_W = OCC_W + 2 * BW_W;
    localparam int DEPTH = 1 << ID_W;

    // ****************************************
    // field positions
    // ****************************************
    localparam int EVT_LO = 0;
    localparam int ID_LO = 32;
    localparam int ERR_BIT = 63;
    localparam int UNAV_BIT = 62;
    localparam int OCC_LO = 0;
    localparam int TOT_LO = OCC_W;
    localparam int LOC_LO = OCC_W + BW_W;

    // ****************************************
    // register selectors, masks, reset values
    // ****************************************
    localparam logic [1:0] REG_ASSOC = 2'h0;
    localparam logic [1:0] REG_SELECT = 2'h1;
    localparam logic [1:0] REG_COUNTER = 2'h2;
    localparam logic [MSR_W-1:0] SEL_RSVD = 64'hffff_fc00_ffff_ff00;
    localparam logic [MSR_W-1:0] ASSOC_RSVD = 64'hffff_ffff_ffff_fc00;
    localparam logic [MSR_W-1:0] SELECT_RST = 64'h0;
    localparam logic [MSR_W-1:0] ASSOC_RST = 64'h0;
    localparam logic [ID_W-1:0] HIGHEST_ID_DEF = 10'h3ff;

    // ****************************************
    // event codes and update kinds
    // ****************************************
    localparam logic [EVT_W-1:0] EVT_OCC = 8'h01;
    localparam logic [EVT_W-1:0] EVT_BW_TOTAL = 8'h02;
    localparam logic [EVT_W-1:0] EVT_BW_LOCAL = 8'h03;

    typedef enum logic [1:0] {
        UPD_OCC_INC,
        UPD_OCC_DEC,
        UPD_BW_TOTAL,
        UPD_BW_LOCAL
    } srmr_upd_t;

endpackage : srmr_pkg

// *** verilog/srmr_readout.sv ***
// shared resource monitor readout: select, counter and association regs
// assumes one register access per cycle, msr_wr wins over msr_rd
//
// Behaviour
// - select bits 7:0 choose the metric
// - select bits 41:32 name the monitoring id
// - no interrupt, counts only sampled by reads
// - no state shared with performance counters
// - unsupported id or event sets bit 63
// - unavailable data sets bit 62
// - data field valid only when 63,62 clear
// - reserved bit write faults with code zero
// - id above highest faults with code zero
// - bandwidth counters 24 bits, wrap on overflow
// - state kept across system management interrupts
// - registers accessible at any time
// - data kept separately per monitoring id
// - events 01 occupancy, 02 total, 03 local
`timescale 1ns/100ps
module srmr_readout
#(
    parameter logic [srmr_pkg::ID_W-1:0] HIGHEST_ID = srmr_pkg::HIGHEST_ID_DEF
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic msr_wr,
    input wire logic msr_rd,
    input wire logic [1:0] msr_sel,
    input wire logic [srmr_pkg::MSR_W-1:0] msr_wdata,
    output logic [srmr_pkg::MSR_W-1:0] msr_rdata,
    output logic msr_ack,
    output logic msr_fault,
    input wire logic upd_valid,
    input wire srmr_pkg::srmr_upd_t upd_kind,
    input wire logic [srmr_pkg::ID_W-1:0] upd_id,
    input wire logic data_unavail,
    output logic [srmr_pkg::ID_W-1:0] active_id
);
    import srmr_pkg::*;

    srmr_store_if st ();

    srmr_id_store u_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .st(st.store)
    );

    // ****************************************
    // register access, stage one
    // ****************************************
    // no sequencing restriction: every access is taken the cycle it comes
    logic [MSR_W-1:0] sel_q, sel_d, assoc_q, assoc_d;
    logic s1_v_q, s1_v_d, s1_fault_q, s1_fault_d, s1_ctr_q, s1_ctr_d;
    logic s1_err_q, s1_err_d, s1_unav_q, s1_unav_d;
    logic [EVT_W-1:0] s1_evt_q, s1_evt_d;
    logic [MSR_W-1:0] s1_data_q, s1_data_d;
    logic [ID_W-1:0] sel_id, wr_id;
    logic [EVT_W-1:0] sel_evt;
    logic evt_ok;

    assign sel_id = sel_q[ID_LO +: ID_W];
    assign sel_evt = sel_q[EVT_LO +: EVT_W];
    assign wr_id = msr_wdata[ID_LO +: ID_W];
    assign evt_ok = (sel_evt == EVT_OCC) || (sel_evt == EVT_BW_TOTAL)
        || (sel_evt == EVT_BW_LOCAL);

    always_comb
    begin
        sel_d = sel_q;
        assoc_d = assoc_q;
        s1_v_d = msr_wr || msr_rd;
        s1_fault_d = 1'b0;
        s1_ctr_d = 1'b0;
        s1_err_d = 1'b0;
        s1_unav_d = 1'b0;
        s1_evt_d = sel_evt;
        s1_data_d = '0;
        if (msr_wr)
        begin
            unique case (msr_sel)
                REG_SELECT:
                begin
                    if (((msr_wdata & SEL_RSVD) != '0)
                        || (wr_id > HIGHEST_ID))
                        s1_fault_d = 1'b1;
                    else
                        sel_d = msr_wdata;
                end
                REG_ASSOC:
                begin
                    if (((msr_wdata & ASSOC_RSVD) != '0)
                        || (msr_wdata[ID_W-1:0] > HIGHEST_ID))
                        s1_fault_d = 1'b1;
                    else
                        assoc_d = msr_wdata;
                end
                default: s1_fault_d = 1'b1;
            endcase
        end
        else if (msr_rd)
        begin
            unique case (msr_sel)
                REG_SELECT: s1_data_d = sel_q;
                REG_ASSOC: s1_data_d = assoc_q;
                REG_COUNTER:
                begin
                    // store read address already tracks sel_q
                    s1_ctr_d = 1'b1;
                    s1_err_d = !evt_ok || (sel_id > HIGHEST_ID);
                    s1_unav_d = data_unavail;
                end
                default: s1_fault_d = 1'b1;
            endcase
        end
    end

    // select and association hold across system management interrupts;
    // only reset or an accepted write changes them
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sel_q <= SELECT_RST;
            assoc_q <= ASSOC_RST;
            s1_v_q <= 1'b0;
            s1_fault_q <= 1'b0;
            s1_ctr_q <= 1'b0;
            s1_err_q <= 1'b0;
            s1_unav_q <= 1'b0;
            s1_evt_q <= '0;
            s1_data_q <= '0;
        end
        else
        begin
            sel_q <= sel_d;
            assoc_q <= assoc_d;
            s1_v_q <= s1_v_d;
            s1_fault_q <= s1_fault_d;
            s1_ctr_q <= s1_ctr_d;
            s1_err_q <= s1_err_d;
            s1_unav_q <= s1_unav_d;
            s1_evt_q <= s1_evt_d;
            s1_data_q <= s1_data_d;
        end
    end

    // ****************************************
    // answer, stage two
    // ****************************************
    logic [MSR_W-1:0] rdata_q, rdata_d;
    logic ack_q, ack_d, fault_q, fault_d;
    logic [FIELD_W-1:0] field;
    logic err, unav;

    assign st.rd_a_addr = sel_id;
    assign err = s1_err_q;
    assign unav = s1_unav_q || !st.rd_a_valid;

    always_comb
    begin
        unique case (s1_evt_q)
            EVT_OCC: field = FIELD_W'(st.rd_a_data[OCC_LO +: OCC_W]);
            EVT_BW_TOTAL: field = FIELD_W'(st.rd_a_data[TOT_LO +: BW_W]);
            EVT_BW_LOCAL: field = FIELD_W'(st.rd_a_data[LOC_LO +: BW_W]);
            default: field = '0;
        endcase
        ack_d = s1_v_q;
        fault_d = s1_fault_q;
        rdata_d = s1_data_q;
        if (s1_ctr_q)
        begin
            // raw count only, byte scaling is left to software
            rdata_d = {err, unav, field};
            if (err || unav)
                rdata_d[FIELD_W-1:0] = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rdata_q <= '0;
            ack_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            fault_q <= fault_d;
        end
    end

    assign msr_rdata = rdata_q;
    assign msr_ack = ack_q;
    assign msr_fault = fault_q;
    assign active_id = assoc_q[ID_W-1:0];
    // no interrupt output exists; counts are private to this block
    // and never feed the general performance counters

    // ****************************************
    // count update pipeline
    // ****************************************
    logic u_v_q, u_v_d, l_v_q, l_v_d;
    srmr_upd_t u_kind_q, u_kind_d;
    logic [ID_W-1:0] u_id_q, u_id_d, l_id_q, l_id_d;
    logic [ENTRY_W-1:0] l_data_q, l_data_d, base, nxt;

    assign st.rd_b_addr = upd_id;

    always_comb
    begin
        u_v_d = upd_valid;
        u_kind_d = upd_kind;
        u_id_d = upd_id;
        // forward last write: the store returns old data on a collision
        if (l_v_q && (l_id_q == u_id_q))
            base = l_data_q;
        else if (st.rd_b_valid)
            base = st.rd_b_data;
        else
            base = '0;
        nxt = base;
        unique case (u_kind_q)
            UPD_OCC_INC:
                nxt[OCC_LO +: OCC_W] = base[OCC_LO +: OCC_W] + 32'h1;
            UPD_OCC_DEC:
                if (base[OCC_LO +: OCC_W] != '0)
                    nxt[OCC_LO +: OCC_W] = base[OCC_LO +: OCC_W] - 32'h1;
            UPD_BW_TOTAL:
                nxt[TOT_LO +: BW_W] = base[TOT_LO +: BW_W] + 24'h1;
            UPD_BW_LOCAL:
                nxt[LOC_LO +: BW_W] = base[LOC_LO +: BW_W] + 24'h1;
        endcase
        l_v_d = u_v_q;
        l_id_d = u_id_q;
        l_data_d = nxt;
    end

    assign st.wr_en = u_v_q;
    assign st.wr_addr = u_id_q;
    assign st.wr_data = nxt;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            u_v_q <= 1'b0;
            u_kind_q <= UPD_OCC_INC;
            u_id_q <= '0;
            l_v_q <= 1'b0;
            l_id_q <= '0;
            l_data_q <= '0;
        end
        else
        begin
            u_v_q <= u_v_d;
            u_kind_q <= u_kind_d;
            u_id_q <= u_id_d;
            l_v_q <= l_v_d;
            l_id_q <= l_id_d;
            l_data_q <= l_data_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_ack_latency: assert property (
        (msr_wr || msr_rd) |-> ##2 msr_ack)
        else $error("access not answered two cycles later");
    chk_ack_cause: assert property (
        msr_ack |-> $past(msr_wr || msr_rd, 2))
        else $error("answer without access");
    chk_rsvd_fault: assert property (
        (msr_wr && msr_sel == REG_SELECT && (msr_wdata & SEL_RSVD) != '0)
        |=> $stable(sel_q) ##1 msr_fault)
        else $error("reserved bit write not refused");
    chk_id_fault: assert property (
        (msr_wr && msr_sel == REG_ASSOC && msr_wdata[ID_W-1:0] > HIGHEST_ID)
        |-> ##2 msr_fault)
        else $error("id above highest not refused");
    chk_assoc_take: assert property (
        (msr_wr && msr_sel == REG_ASSOC && (msr_wdata & ASSOC_RSVD) == '0
        && msr_wdata[ID_W-1:0] <= HIGHEST_ID)
        |=> active_id == $past(msr_wdata[ID_W-1:0]) ##1 !msr_fault)
        else $error("association write lost");
    chk_err_bit: assert property (
        (msr_rd && !msr_wr && msr_sel == REG_COUNTER && !evt_ok)
        |-> ##2 msr_rdata[ERR_BIT])
        else $error("unsupported event without error flag");
    chk_unav_bit: assert property (
        (msr_rd && !msr_wr && msr_sel == REG_COUNTER && data_unavail)
        |-> ##2 msr_rdata[UNAV_BIT])
        else $error("unavailable data without flag");
    chk_field_zero: assert property (
        (msr_ack && (msr_rdata[ERR_BIT] || msr_rdata[UNAV_BIT]))
        |-> msr_rdata[FIELD_W-1:0] == '0)
        else $error("data field set with a flag");
    chk_fwd_write: assert property (
        upd_valid |=> st.wr_en && st.wr_addr == $past(upd_id))
        else $error("update not written");

endmodule : srmr_readout

// *** verilog/srmr_store_if.sv ***
// signals between the readout logic and its per-id store
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface srmr_store_if;
    logic [srmr_pkg::ID_W-1:0] rd_a_addr;
    logic [srmr_pkg::ENTRY_W-1:0] rd_a_data;
    logic rd_a_valid;
    logic [srmr_pkg::ID_W-1:0] rd_b_addr;
    logic [srmr_pkg::ENTRY_W-1:0] rd_b_data;
    logic rd_b_valid;
    logic wr_en;
    logic [srmr_pkg::ID_W-1:0] wr_addr;
    logic [srmr_pkg::ENTRY_W-1:0] wr_data;

    modport ctrl (
        output rd_a_addr,
        input rd_a_data,
        input rd_a_valid,
        output rd_b_addr,
        input rd_b_data,
        input rd_b_valid,
        output wr_en,
        output wr_addr,
        output wr_data
    );
    modport store (
        input rd_a_addr,
        output rd_a_data,
        output rd_a_valid,
        input rd_b_addr,
        output rd_b_data,
        output rd_b_valid,
        input wr_en,
        input wr_addr,
        input wr_data
    );
endinterface : srmr_store_if
